// File: hw/dss_pkg.sv
package dss_pkg;

	// Register byte addresses on the 32-bit bus.
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_TOL    = 8'h04;
	localparam logic [7:0] ADR_RAMP   = 8'h08;
	localparam logic [7:0] ADR_PLLDLY = 8'h0c;
	localparam logic [7:0] ADR_RTTIME = 8'h10;
	localparam logic [7:0] ADR_SETPT  = 8'h14;
	localparam logic [7:0] ADR_RTSTEP = 8'h18;
	localparam logic [7:0] ADR_RTTHR  = 8'h1c;
	localparam logic [7:0] ADR_STATUS = 8'h20;
	localparam logic [7:0] ADR_FREQ   = 8'h24;

	// Control register fields.
	localparam int CTL_SW_EN    = 0;
	localparam int CTL_DIR_DOWN = 1;
	localparam int CTL_TRACK    = 2;
	localparam int CTL_FREESTOP = 3;
	localparam int CTL_DEBUG    = 4;
	localparam int CTL_RIDE     = 5;
	localparam int CTL_QBREAK   = 6;
	localparam int CTL_AUTORST  = 7;
	localparam int CTL_FLTCLR   = 8;
	localparam int CTL_W        = 8;

	// Status register fields.
	localparam int STS_STATE  = 0;
	localparam int STS_LOCK   = 4;
	localparam int STS_PERMIT = 5;
	localparam int STS_PLLEN  = 6;
	localparam int STS_CONT   = 7;
	localparam int STS_RIDE   = 8;
	localparam int STS_LOSS   = 9;

	// Reset values.
	localparam logic [7:0]  RST_CTRL   = 8'h0c;
	localparam logic [7:0]  RST_TOL    = 8'h32;
	localparam logic [15:0] RST_RAMP   = 16'h03e8;
	localparam logic [23:0] RST_PLLDLY = 24'h0007d0;
	localparam logic [15:0] RST_RTTIME = 16'h012c;
	localparam logic [15:0] RST_SETPT  = 16'h1388;
	localparam logic [15:0] RST_RTSTEP = 16'h0012;
	localparam logic [15:0] RST_RTTHR  = 16'h03e8;

	// Phase tolerance limits in 0.1 degree.
	localparam logic [7:0] TOL_MIN = 8'h05;
	localparam logic [7:0] TOL_MAX = 8'h50;

	// Thresholds: frequency in 0.01 Hz, current in percent.
	localparam logic [15:0] FREQ_MIN_TRACK = 16'h00c8;
	localparam logic [7:0]  CUR_DISCONN    = 8'h0a;

	// Timing.
	localparam int CLK_NS       = 50;
	localparam int TICK_NS      = 1000000;
	localparam int TICK_CYC     = TICK_NS / CLK_NS;
	localparam int RECOVER_S    = 10;
	localparam int RECOVER_MS   = RECOVER_S * 1000;

	typedef enum logic [3:0] {
		ST_STANDBY = 4'b0000,
		ST_START   = 4'b0001,
		ST_RUN     = 4'b0010,
		ST_SW_FREQ = 4'b0011,
		ST_SW_PH   = 4'b0100,
		ST_SW_LOCK = 4'b0101,
		ST_COAST   = 4'b0110,
		ST_DN_TRK  = 4'b0111,
		ST_RIDE    = 4'b1000,
		ST_LOSS    = 4'b1001,
		ST_UNREADY = 4'b1010,
		ST_FAULT   = 4'b1011
	} dss_state_t;

endpackage

// File: hw/dss_top.sv
//Behaviour
//RULE1 - Upward switch adopts grid frequency as command
//RULE2 - Phase alignment starts only after frequency match
//RULE3 - Lock flags permit; after switch open, coast
//RULE4 - Lock angle tolerance configurable 0.5 to 8 degrees
//RULE5 - Downward: run unloaded, lock, take over when connected
//RULE6 - Activation input starts drag; output permits cabinet
//RULE7 - Tracking start outputs motor frequency, then ramps
//RULE8 - Runaway time holds frequency while voltage ramps
//RULE9 - Tracking released after disabling delay since shutdown
//RULE10 - Tracking loop disabled at first power-up
//RULE11 - Tracking loop refused in debug mode
//RULE12 - Tracking loop off below 2 Hz
//RULE13 - Shutdown current below 10 percent disables tracking
//RULE14 - Otherwise tracking follows motor frequency continuously
//RULE15 - Below 2 Hz within delay disables tracking
//RULE16 - Ride-through decelerates to hold bus voltage
//RULE17 - Sag past ride-through time with quick break faults
//RULE18 - Sag longer than ride-through time is power loss
//RULE19 - Suggested settings 300 ms, step 18, threshold 1000
//RULE20 - Quick break: loss from standby or run faults
//RULE21 - Standby loss: recover in 10 s else unready
//RULE22 - Running loss: restart, standby or major fault
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module dss_top
	import dss_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int RECOVER_TICKS = RECOVER_MS
) (
	// Clock, reset and enable.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Commands and cabinet feedback.
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic        switch_act_i,
	input  wire logic        switch_done_i,
	// Measurements.
	input  wire logic [15:0] grid_freq_i,
	input  wire logic [15:0] motor_freq_i,
	input  wire logic [15:0] phase_err_i,
	input  wire logic        volt_match_i,
	input  wire logic [7:0]  out_curr_pct_i,
	input  wire logic        grid_sag_i,
	input  wire logic [15:0] dc_bus_i,
	// Drive outputs.
	output logic      [15:0] speed_cmd_o,
	output logic      [15:0] volt_cmd_o,
	output logic             run_o,
	output logic             out_contactor_o,
	output logic             lock_ok_o,
	output logic             switch_permit_o,
	output logic             track_en_o,
	output logic             loss_fault_o,
	output logic             unready_o
);

	////////////////////////////////////////////////////////////////////////
	// Registers and state.

	logic [CTL_W-1:0] ctrl_ff;
	logic [7:0]       tol_ff;
	logic [15:0]      ramp_ff;
	logic [23:0]      plldly_ff;
	logic [15:0]      rttime_ff;
	logic [15:0]      setpt_ff;
	logic [15:0]      rtstep_ff;
	logic [15:0]      rtthr_ff;
	logic             ack_ff;
	logic [31:0]      rdat_ff;
	logic             flt_clr_ff;
	dss_state_t       state_ff;
	dss_state_t       nxt_state;
	logic [15:0]      speed_ff;
	logic [15:0]      volt_ff;
	logic             lock_ff;
	logic             permit_ff;
	logic             cont_ff;
	logic             run_ff;
	logic             pll_en_ff;
	logic             armed_ff;
	logic             low_cur_ff;
	logic             shut_ff;
	logic [23:0]      dly_ms_ff;
	logic [15:0]      trk_freq_ff;
	logic             was_run_ff;
	logic [15:0]      sag_ms_ff;
	logic [15:0]      ms_cnt_ff;
	logic [15:0]      rec_ms_ff;
	logic [15:0]      tick_cnt_ff;
	logic             tick_ff;

	logic        bus_req;
	logic        bus_wr;
	logic [31:0] wmask;
	logic [15:0] ph_abs;
	logic        freq_match;
	logic        ph_ok;
	logic        loss_evt;
	logic        sw_up_req;
	logic        sw_dn_req;
	logic        pll_block;
	logic [7:0]  tol_wr;
	logic [15:0] volt_tgt;
	logic [31:0] volt_prod;
	logic [15:0] volt_ramp;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state, every access answered with ack.

	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_wr  = bus_req && wb_we_i;
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		tol_wr = (wb_dat_i[7:0] & wmask[7:0]) | (tol_ff & ~wmask[7:0]);
		if (tol_wr < TOL_MIN) begin
			tol_wr = TOL_MIN;
		end else if (tol_wr > TOL_MAX) begin
			tol_wr = TOL_MAX;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else if (ce_i) begin
			ack_ff <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff    <= RST_CTRL;
			tol_ff     <= RST_TOL;
			ramp_ff    <= RST_RAMP;
			plldly_ff  <= RST_PLLDLY;
			rttime_ff  <= RST_RTTIME;
			setpt_ff   <= RST_SETPT;
			rtstep_ff  <= RST_RTSTEP;
			rtthr_ff   <= RST_RTTHR;
			flt_clr_ff <= 1'b0;
		end else if (ce_i) begin
			flt_clr_ff <= bus_wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[1]
			              && wb_dat_i[CTL_FLTCLR];
			if (bus_wr) begin
				case (wb_adr_i)
					ADR_CTRL: begin
						ctrl_ff <= (wb_dat_i[CTL_W-1:0] & wmask[CTL_W-1:0])
						           | (ctrl_ff & ~wmask[CTL_W-1:0]);
					end
					ADR_TOL: begin
						tol_ff <= tol_wr; // [RULE4]
					end
					ADR_RAMP: begin
						ramp_ff <= (wb_dat_i[15:0] & wmask[15:0])
						           | (ramp_ff & ~wmask[15:0]);
					end
					ADR_PLLDLY: begin
						plldly_ff <= (wb_dat_i[23:0] & wmask[23:0])
						             | (plldly_ff & ~wmask[23:0]);
					end
					ADR_RTTIME: begin
						rttime_ff <= (wb_dat_i[15:0] & wmask[15:0])
						             | (rttime_ff & ~wmask[15:0]);
					end
					ADR_SETPT: begin
						setpt_ff <= (wb_dat_i[15:0] & wmask[15:0])
						            | (setpt_ff & ~wmask[15:0]);
					end
					ADR_RTSTEP: begin
						rtstep_ff <= (wb_dat_i[15:0] & wmask[15:0])
						             | (rtstep_ff & ~wmask[15:0]);
					end
					ADR_RTTHR: begin
						rtthr_ff <= (wb_dat_i[15:0] & wmask[15:0])
						            | (rtthr_ff & ~wmask[15:0]);
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_ff <= 32'h00000000;
		end else if (ce_i) begin
			rdat_ff <= 32'h00000000;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					ADR_CTRL:   rdat_ff[CTL_W-1:0] <= ctrl_ff;
					ADR_TOL:    rdat_ff[7:0]       <= tol_ff;
					ADR_RAMP:   rdat_ff[15:0]      <= ramp_ff;
					ADR_PLLDLY: rdat_ff[23:0]      <= plldly_ff;
					ADR_RTTIME: rdat_ff[15:0]      <= rttime_ff;
					ADR_SETPT:  rdat_ff[15:0]      <= setpt_ff;
					ADR_RTSTEP: rdat_ff[15:0]      <= rtstep_ff;
					ADR_RTTHR:  rdat_ff[15:0]      <= rtthr_ff;
					ADR_STATUS: begin
						rdat_ff[STS_STATE+3:STS_STATE] <= state_ff;
						rdat_ff[STS_LOCK]   <= lock_ff;
						rdat_ff[STS_PERMIT] <= permit_ff;
						rdat_ff[STS_PLLEN]  <= pll_en_ff;
						rdat_ff[STS_CONT]   <= cont_ff;
						rdat_ff[STS_RIDE]   <= (state_ff == ST_RIDE);
						rdat_ff[STS_LOSS]   <= (state_ff == ST_LOSS);
					end
					ADR_FREQ: rdat_ff <= {trk_freq_ff, speed_ff};
					default:  rdat_ff <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff     <= 1'b0;
		end else if (ce_i) begin
			tick_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1));
			if (tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
				tick_cnt_ff <= 16'h0000;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Matching terms.

	assign ph_abs     = phase_err_i[15] ? 16'(-phase_err_i) : phase_err_i;
	assign freq_match = (speed_ff == grid_freq_i);
	assign ph_ok      = freq_match && volt_match_i
	                    && (ph_abs <= {8'h00, tol_ff}); // [RULE3] [RULE4]
	assign loss_evt   = grid_sag_i && (sag_ms_ff >= rttime_ff); // [RULE18]
	assign sw_up_req  = ctrl_ff[CTL_SW_EN] && !ctrl_ff[CTL_DIR_DOWN]
	                    && switch_act_i; // [RULE6]
	assign sw_dn_req  = ctrl_ff[CTL_SW_EN] && ctrl_ff[CTL_DIR_DOWN]
	                    && switch_act_i;
	assign volt_tgt   = speed_ff;
	assign volt_prod  = volt_tgt * ms_cnt_ff;
	assign volt_ramp  = (ramp_ff == 16'h0000) ? volt_tgt
	                    : 16'(volt_prod / {16'h0000, ramp_ff});

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sag_ms_ff <= 16'h0000;
		end else if (ce_i) begin
			if (!grid_sag_i) begin
				sag_ms_ff <= 16'h0000;
			end else if (tick_ff && sag_ms_ff != 16'hffff) begin
				sag_ms_ff <= sag_ms_ff + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Motor-frequency tracking loop enable.

	assign pll_block = ctrl_ff[CTL_DEBUG] // [RULE11]
	                   || (motor_freq_i < FREQ_MIN_TRACK) // [RULE12] [RULE15]
	                   || low_cur_ff // [RULE13]
	                   || !armed_ff // [RULE10]
	                   || (shut_ff && dly_ms_ff >= plldly_ff); // [RULE9]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_en_ff   <= 1'b0; // [RULE10]
			trk_freq_ff <= 16'h0000;
		end else if (ce_i) begin
			pll_en_ff <= !pll_block; // [RULE14]
			if (!pll_block) begin
				trk_freq_ff <= motor_freq_i; // [RULE14]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_ff   <= 1'b0;
			shut_ff    <= 1'b0;
			low_cur_ff <= 1'b0;
			dly_ms_ff  <= 24'h000000;
		end else if (ce_i) begin
			if (state_ff == ST_RUN && stop_i) begin
				shut_ff    <= 1'b1;
				dly_ms_ff  <= 24'h000000;
				low_cur_ff <= (out_curr_pct_i < CUR_DISCONN); // [RULE13]
			end else if (nxt_state == ST_START || nxt_state == ST_RUN) begin
				armed_ff   <= 1'b1;
				shut_ff    <= 1'b0;
				low_cur_ff <= 1'b0;
			end else if (shut_ff && tick_ff && dly_ms_ff != 24'hffffff) begin
				dly_ms_ff <= dly_ms_ff + 24'h000001; // [RULE9]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_STANDBY: begin
				if (loss_evt) begin
					nxt_state = ctrl_ff[CTL_QBREAK] ? ST_FAULT : ST_LOSS;
				end else if (sw_dn_req) begin
					nxt_state = ST_DN_TRK; // [RULE5]
				end else if (start_i) begin
					nxt_state = ST_START;
				end
			end
			ST_START: begin
				if (stop_i) begin
					nxt_state = ST_STANDBY;
				end else if (ms_cnt_ff >= ramp_ff) begin
					nxt_state = ST_RUN; // [RULE8]
				end
			end
			ST_RUN: begin
				if (stop_i) begin
					nxt_state = ST_STANDBY;
				end else if (grid_sag_i && ctrl_ff[CTL_RIDE]) begin
					nxt_state = ST_RIDE; // [RULE16]
				end else if (loss_evt) begin
					nxt_state = ctrl_ff[CTL_QBREAK] ? ST_FAULT : ST_LOSS;
				end else if (sw_up_req) begin
					nxt_state = ST_SW_FREQ; // [RULE1]
				end
			end
			ST_SW_FREQ: begin
				if (!sw_up_req || stop_i) begin
					nxt_state = ST_RUN;
				end else if (freq_match) begin
					nxt_state = ST_SW_PH; // [RULE2]
				end
			end
			ST_SW_PH: begin
				if (!sw_up_req || stop_i) begin
					nxt_state = ST_RUN;
				end else if (!freq_match) begin
					nxt_state = ST_SW_FREQ;
				end else if (ph_ok) begin
					nxt_state = ST_SW_LOCK; // [RULE3]
				end
			end
			ST_SW_LOCK: begin
				if (switch_done_i) begin
					nxt_state = ST_COAST; // [RULE3]
				end else if (!sw_up_req || stop_i) begin
					nxt_state = ST_RUN;
				end else if (!ph_ok) begin
					nxt_state = ST_SW_PH;
				end
			end
			ST_COAST: begin
				if (!switch_act_i) begin
					nxt_state = ST_STANDBY;
				end
			end
			ST_DN_TRK: begin
				if (!sw_dn_req || stop_i) begin
					nxt_state = ST_STANDBY;
				end else if (switch_done_i && ph_ok) begin
					nxt_state = ST_RUN; // [RULE5]
				end
			end
			ST_RIDE: begin
				if (!grid_sag_i) begin
					nxt_state = ST_RUN;
				end else if (loss_evt) begin
					nxt_state = ctrl_ff[CTL_QBREAK] ? ST_FAULT // [RULE17]
					                                : ST_LOSS;
				end
			end
			ST_LOSS: begin
				if (!grid_sag_i) begin
					nxt_state = (was_run_ff && ctrl_ff[CTL_AUTORST])
					            ? ST_RUN : ST_STANDBY; // [RULE21] [RULE22]
				end else if (rec_ms_ff >= 16'(RECOVER_TICKS)) begin
					nxt_state = was_run_ff ? (ctrl_ff[CTL_AUTORST]
					            ? ST_UNREADY : ST_FAULT) // [RULE22]
					            : ST_UNREADY; // [RULE21]
				end
			end
			ST_UNREADY: begin
				if (!grid_sag_i) begin
					nxt_state = ST_STANDBY;
				end
			end
			ST_FAULT: begin
				if (flt_clr_ff && !grid_sag_i) begin
					nxt_state = ST_STANDBY;
				end
			end
			default: begin
				nxt_state = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff   <= ST_STANDBY;
			was_run_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state; // [RULE20]
			if (nxt_state == ST_LOSS && state_ff != ST_LOSS) begin
				was_run_ff <= (state_ff != ST_STANDBY);
			end
		end
	end

	// Millisecond counters for the voltage ramp and the recovery window.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_cnt_ff <= 16'h0000;
			rec_ms_ff <= 16'h0000;
		end else if (ce_i) begin
			if (nxt_state != state_ff) begin
				ms_cnt_ff <= 16'h0000;
				rec_ms_ff <= 16'h0000;
			end else if (tick_ff) begin
				if (ms_cnt_ff != 16'hffff) begin
					ms_cnt_ff <= ms_cnt_ff + 16'h0001;
				end
				if (state_ff == ST_LOSS && rec_ms_ff != 16'hffff) begin
					rec_ms_ff <= rec_ms_ff + 16'h0001; // [RULE21]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frequency and voltage commands.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			speed_ff <= 16'h0000;
			volt_ff  <= 16'h0000;
		end else if (ce_i) begin
			case (state_ff)
				ST_STANDBY: begin
					volt_ff <= 16'h0000;
					if (nxt_state == ST_START) begin
						speed_ff <= (ctrl_ff[CTL_TRACK] && ctrl_ff[CTL_FREESTOP]
						             && pll_en_ff) ? trk_freq_ff // [RULE7]
						                           : 16'h0000;
					end else if (nxt_state == ST_DN_TRK) begin
						speed_ff <= grid_freq_i;
					end else begin
						speed_ff <= 16'h0000;
					end
				end
				ST_START: begin
					volt_ff <= volt_ramp; // [RULE8]
				end
				ST_RUN: begin
					volt_ff <= volt_tgt;
					if (tick_ff && speed_ff < setpt_ff) begin
						speed_ff <= speed_ff + 16'h0001; // [RULE7]
					end else if (tick_ff && speed_ff > setpt_ff) begin
						speed_ff <= speed_ff - 16'h0001;
					end
				end
				ST_SW_FREQ, ST_SW_PH, ST_SW_LOCK, ST_DN_TRK: begin
					volt_ff <= volt_tgt;
					if (tick_ff && speed_ff < grid_freq_i) begin
						speed_ff <= speed_ff + 16'h0001; // [RULE1]
					end else if (tick_ff && speed_ff > grid_freq_i) begin
						speed_ff <= speed_ff - 16'h0001; // [RULE1]
					end
				end
				ST_RIDE: begin
					volt_ff <= volt_tgt;
					if (tick_ff && dc_bus_i < rtthr_ff) begin
						speed_ff <= (speed_ff > rtstep_ff)
						            ? speed_ff - rtstep_ff : 16'h0000; // [RULE16]
					end
				end
				default: begin
					speed_ff <= 16'h0000;
					volt_ff  <= 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_ff   <= 1'b0;
			permit_ff <= 1'b0;
			cont_ff   <= 1'b0;
			run_ff    <= 1'b0;
		end else if (ce_i) begin
			lock_ff   <= (nxt_state == ST_SW_LOCK)
			             || (nxt_state == ST_DN_TRK && ph_ok); // [RULE3]
			permit_ff <= (nxt_state == ST_SW_LOCK)
			             || (nxt_state == ST_DN_TRK && ph_ok); // [RULE6]
			cont_ff   <= (nxt_state == ST_START) || (nxt_state == ST_RUN)
			             || (nxt_state == ST_SW_FREQ) || (nxt_state == ST_SW_PH)
			             || (nxt_state == ST_SW_LOCK)
			             || (nxt_state == ST_RIDE); // [RULE3] [RULE5]
			run_ff    <= (nxt_state != ST_STANDBY) && (nxt_state != ST_COAST)
			             && (nxt_state != ST_LOSS) && (nxt_state != ST_UNREADY)
			             && (nxt_state != ST_FAULT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign wb_dat_o        = rdat_ff;
	assign wb_ack_o        = ack_ff;
	assign speed_cmd_o     = speed_ff;
	assign volt_cmd_o      = volt_ff;
	assign run_o           = run_ff;
	assign out_contactor_o = cont_ff;
	assign lock_ok_o       = lock_ff;
	assign switch_permit_o = permit_ff;
	assign track_en_o      = pll_en_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loss_fault_o <= 1'b0;
			unready_o    <= 1'b0;
		end else if (ce_i) begin
			loss_fault_o <= (nxt_state == ST_FAULT); // [RULE20]
			unready_o    <= (nxt_state == ST_UNREADY);
		end
	end

endmodule

`default_nettype wire

// File: verif/dss_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dss_top_asserts
	import dss_pkg::*;
(
	// Clock and bus.
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Drive.
	input wire logic [15:0] motor_freq_i,
	input wire logic        run_o,
	input wire logic        lock_ok_o,
	input wire logic        switch_permit_o,
	input wire logic        track_en_o,
	input wire logic        loss_fault_o,
	input wire logic        unready_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus not acked");
	property p_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("data without ack");
	property p_rst;
		$past(rst_i) |-> !track_en_o && !run_o && !lock_ok_o;
	endproperty
	a_rst: assert property (p_rst) else $error("busy after reset");
	property p_low;
		(motor_freq_i < FREQ_MIN_TRACK)[*8] |-> !track_en_o;
	endproperty
	a_low: assert property (p_low) else $error("tracking too slow");
	property p_perm;
		switch_permit_o |-> lock_ok_o;
	endproperty
	a_perm: assert property (p_perm) else $error("permit unlocked");
	property p_fault;
		loss_fault_o |-> !run_o && !unready_o;
	endproperty
	a_fault: assert property (p_fault) else $error("fault mixed");
	property p_unr;
		unready_o |-> !run_o && !lock_ok_o;
	endproperty
	a_unr: assert property (p_unr) else $error("unready mixed");
endmodule
bind dss_top dss_top_asserts i_dss_top_asserts (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .wb_dat_o, .motor_freq_i, .run_o, .lock_ok_o,
	.switch_permit_o, .track_en_o, .loss_fault_o, .unready_o);
`default_nettype wire

// File: verif/dss_plant.sv
`timescale 1ns/100ps
`default_nettype none
module dss_plant (
	// Drive and bench.
	input  wire logic        clk_i,
	input  wire logic        run_i,
	input  wire logic [15:0] speed_i,
	input  wire logic [15:0] grid_i,
	input  wire logic        permit_i,
	input  wire logic        act_i,
	input  wire logic [15:0] idle_freq_i,
	// Measurements and cabinet.
	output logic      [15:0] motor_freq_o,
	output logic      [15:0] phase_err_o = 16'h0064,
	output logic             volt_match_o,
	output logic             done_o = 1'b0
);
	logic [2:0] dly_ff = 3'h0;
	assign motor_freq_o = run_i ? speed_i : idle_freq_i;
	assign volt_match_o = speed_i == grid_i;
	// Phase only slides toward zero once the frequencies agree.
	always @(posedge clk_i) begin
		if (speed_i != grid_i)
			phase_err_o <= 16'h0064;
		else if (phase_err_o != 16'h0)
			phase_err_o <= phase_err_o - 16'h1;
	end
	// The cabinet closes a few cycles after the permit.
	always @(posedge clk_i) begin
		dly_ff <= permit_i ? dly_ff + 3'h1 : 3'h0;
		if (!act_i)
			done_o <= 1'b0;
		else if (dly_ff == 3'h7)
			done_o <= 1'b1;
	end
endmodule
`default_nettype wire

// File: verif/dss_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dss_top_tb
	import dss_pkg::*;
;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
	logic        wb_we_i = 0, wb_ack_o, start_i = 0, stop_i = 0;
	logic        switch_act_i = 0, switch_done_i, grid_sag_i = 0;
	logic        volt_match_i, run_o, out_contactor_o, lock_ok_o;
	logic        switch_permit_o, track_en_o, loss_fault_o, unready_o;
	logic [7:0]  wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic [15:0] grid_freq_i = 16'h1e, idle_f = 0, motor_freq_i;
	logic [15:0] phase_err_i, speed_cmd_o, volt_cmd_o;
	logic [7:0]  cur = 8'h32;
	int          n_mismatch = 0, num_checks = 0;
	always #25 clk_i = ~clk_i;
	dss_top #(.TICK_CYCLES(20), .RECOVER_TICKS(50)) i_dss_top (.clk_i,
		.rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .start_i, .stop_i,
		.switch_act_i, .switch_done_i, .grid_freq_i, .motor_freq_i,
		.phase_err_i, .volt_match_i, .out_curr_pct_i(cur), .grid_sag_i,
		.dc_bus_i(16'h0), .speed_cmd_o, .volt_cmd_o, .run_o,
		.out_contactor_o, .lock_ok_o, .switch_permit_o, .track_en_o,
		.loss_fault_o, .unready_o);
	dss_plant i_dss_plant (.clk_i, .run_i(run_o), .speed_i(speed_cmd_o),
		.grid_i(grid_freq_i), .permit_i(switch_permit_o),
		.act_i(switch_act_i), .idle_freq_i(idle_f),
		.motor_freq_o(motor_freq_i), .phase_err_o(phase_err_i),
		.volt_match_o(volt_match_i), .done_o(switch_done_i));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e, input string m);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic waitfor(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(s), 32'(v), "wait timed out");
		if (s !== v)
			wrap_up();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		waitfor(wb_ack_o, 1, 50);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, logic [31:0] e, string m);
		bus(0, a, 0);
		chk(rd, e, m);
	endtask
	task automatic go;
		start_i <= 1;
		waitfor(run_o, 1, 3000);
		start_i <= 0;
		repeat (500) @(posedge clk_i);
	endtask
	task automatic sag(input int n);
		grid_sag_i <= 1;
		repeat (n) @(posedge clk_i);
		grid_sag_i <= 0;
	endtask
	task automatic t_regs;
		rdchk(ADR_CTRL, 32'(RST_CTRL), "ctrl reset");
		rdchk(ADR_RTTIME, 32'(RST_RTTIME), "time reset");
		rdchk(ADR_RTSTEP, 32'(RST_RTSTEP), "step reset");
		rdchk(ADR_RTTHR, 32'(RST_RTTHR), "thr reset");
		rdchk(8'h30, 32'h0, "unmapped");
		bus(1, ADR_TOL, 32'h1);
		rdchk(ADR_TOL, 32'(TOL_MIN), "tol low");
		bus(1, ADR_TOL, 32'hff);
		rdchk(ADR_TOL, 32'(TOL_MAX), "tol high");
		bus(1, ADR_TOL, 32'h1e);
		rdchk(ADR_TOL, 32'h1e, "tol mid");
		bus(1, ADR_SETPT, 32'h14);
		bus(1, ADR_RAMP, 32'h5);
		bus(1, ADR_RTTIME, 32'ha);
		$display("regs done");
	endtask
	task automatic t_up;
		bus(1, ADR_CTRL, 32'hd);
		go();
		switch_act_i <= 1;
		waitfor(lock_ok_o, 1, 3000);
		chk(32'(speed_cmd_o), 32'h1e, "not grid");
		chk(32'(out_contactor_o), 32'h1, "contactor");
		@(posedge clk_i);
		chk(32'(switch_permit_o), 32'h1, "no permit");
		waitfor(out_contactor_o, 0, 100);
		@(posedge clk_i);
		chk(32'(run_o), 32'h0, "no coast");
		switch_act_i <= 0;
		bus(1, ADR_CTRL, 32'hf);
		switch_act_i <= 1;
		waitfor(out_contactor_o, 1, 300);
		switch_act_i <= 0;
		stop_i <= 1;
		waitfor(run_o, 0, 20);
		stop_i <= 0;
		$display("switch done");
	endtask
	task automatic t_track;
		idle_f <= 16'h12c;
		repeat (5) @(posedge clk_i);
		chk(32'(track_en_o), 32'h1, "track off");
		bus(1, ADR_CTRL, 32'h1c);
		repeat (3) @(posedge clk_i);
		chk(32'(track_en_o), 32'h0, "debug track");
		bus(1, ADR_CTRL, 32'hc);
		waitfor(track_en_o, 1, 10);
		start_i <= 1;
		repeat (3) @(posedge clk_i);
		chk(32'(speed_cmd_o), 32'h12c, "no match");
		repeat (60) @(posedge clk_i);
		chk(32'(speed_cmd_o), 32'h12c, "ramp moved");
		chk(32'(volt_cmd_o inside {[1:299]}), 32'h1, "vramp");
		repeat (80) @(posedge clk_i);
		cur <= 8'h5;
		waitfor(run_o, 1, 3000);
		start_i <= 0;
		stop_i <= 1;
		waitfor(run_o, 0, 100);
		stop_i <= 0;
		repeat (3) @(posedge clk_i);
		chk(32'(track_en_o), 32'h0, "low current");
		cur <= 8'h32;
		idle_f <= 16'h64;
		repeat (12) @(posedge clk_i);
		chk(32'(track_en_o), 32'h0, "slow track");
		$display("track done");
	endtask
	task automatic t_loss;
		for (int i = 0; i < 2; i++) begin
			bus(1, ADR_CTRL, 32'h6c);
			if (i == 1)
				go();
			grid_sag_i <= 1;
			repeat (60) @(posedge clk_i);
			if (i == 1)
				chk(32'(speed_cmd_o == 16'h0), 32'h1, "no decel");
			chk(32'(loss_fault_o), 32'h0, "early");
			waitfor(loss_fault_o, 1, 300);
			grid_sag_i <= 0;
			bus(1, ADR_CTRL, 32'h16c);
			waitfor(loss_fault_o, 0, 20);
		end
		bus(1, ADR_CTRL, 32'hc);
		sag(400);
		repeat (5) @(posedge clk_i);
		chk(32'({unready_o, loss_fault_o}), 32'h0, "recover");
		grid_sag_i <= 1;
		waitfor(unready_o, 1, 1500);
		chk(32'(loss_fault_o), 32'h0, "standby fault");
		grid_sag_i <= 0;
		waitfor(unready_o, 0, 20);
		bus(1, ADR_CTRL, 32'h8c);
		go();
		sag(400);
		waitfor(run_o, 1, 100);
		bus(1, ADR_CTRL, 32'hc);
		grid_sag_i <= 1;
		waitfor(loss_fault_o, 1, 1500);
		grid_sag_i <= 0;
		bus(1, ADR_CTRL, 32'h10c);
		waitfor(loss_fault_o, 0, 20);
		$display("loss done");
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_regs();
		t_up();
		t_track();
		t_loss();
		wrap_up();
	end
endmodule
`default_nettype wire
